// [inc/rtc_pkg.sv]
package rtc_pkg;

   // -------------------------------------------------------------------------
   // Register addresses
   // -------------------------------------------------------------------------
   localparam logic [3:0] RTC_ADDR_MONTH      = 4'h5;
   localparam logic [3:0] RTC_ADDR_YEAR       = 4'h6;
   localparam logic [3:0] RTC_ADDR_TRIM       = 4'h7;
   localparam logic [3:0] RTC_ADDR_A_MINUTE   = 4'h8;
   localparam logic [3:0] RTC_ADDR_A_HOUR     = 4'h9;
   localparam logic [3:0] RTC_ADDR_A_WEEKDAYS = 4'hA;
   localparam logic [3:0] RTC_ADDR_B_MINUTE   = 4'hB;
   localparam logic [3:0] RTC_ADDR_B_HOUR     = 4'hC;
   localparam logic [3:0] RTC_ADDR_B_WEEKDAYS = 4'hD;

   // -------------------------------------------------------------------------
   // Field masks and positions
   // -------------------------------------------------------------------------
   localparam logic [7:0] RTC_MONTH_MASK   = 8'h1F;
   localparam logic [7:0] RTC_YEAR_MASK    = 8'hFF;
   localparam logic [7:0] RTC_MINUTE_MASK  = 8'h7F;
   localparam logic [7:0] RTC_HOUR_MASK    = 8'h3F;
   localparam logic [7:0] RTC_WEEKDAY_MASK = 8'h7F;
   localparam int         RTC_TRIM_XSEL_BIT = 7;
   localparam int         RTC_TRIM_SIGN_BIT = 6;

   // -------------------------------------------------------------------------
   // Values after reset
   // -------------------------------------------------------------------------
   localparam logic [7:0] RTC_REG_RESET  = 8'h00;
   localparam logic [7:0] RTC_TRIM_RESET = 8'h00;

   // -------------------------------------------------------------------------
   // Oscillator pulse counts per second and trim window seconds
   // -------------------------------------------------------------------------
   localparam int          RTC_CNT_W         = 16;
   localparam logic [15:0] RTC_PULSES_32768  = 16'h8000;
   localparam logic [15:0] RTC_PULSES_32000  = 16'h7D00;
   localparam logic [7:0]  RTC_TRIM_SEC_00   = 8'h00;
   localparam logic [7:0]  RTC_TRIM_SEC_20   = 8'h20;
   localparam logic [7:0]  RTC_TRIM_SEC_40   = 8'h40;
   localparam logic [2:0]  RTC_WEEKDAY_ILLEGAL = 3'h7;

endpackage

// [src/rtc_sec_prescaler.sv]
`timescale 1ns/1ns
module rtc_sec_prescaler #(
   parameter int CNT_W = 16
) (
   // Clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rstn,
   // Oscillator pulse and length of the current second
   input  wire logic             osc_edge,
   input  wire logic [CNT_W-1:0] period,
   // One-second event
   output logic                  second_tick
);
   import rtc_pkg::*;

   logic [CNT_W-1:0] pulse_count;
   logic [CNT_W-1:0] next_pulse_count;
   logic             next_second_tick;
   wire              last_pulse;

   // -------------------------------------------------------------------------
   // Pulse counter
   // -------------------------------------------------------------------------
   // The period is sampled at every pulse, so a new length takes effect at once.
   assign last_pulse       = osc_edge && (pulse_count >= CNT_W'(period - 1'b1));
   assign next_pulse_count = last_pulse ? '0 :
                             osc_edge   ? CNT_W'(pulse_count + 1'b1) : pulse_count;
   assign next_second_tick = last_pulse;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pulse_count <= '0;
         second_tick <= 1'b0;
      end else begin
         pulse_count <= next_pulse_count;
         second_tick <= next_second_tick;
      end
   end

endmodule

// [src/rtc_calendar_trim_alarm.sv]
// Behaviour
// RULE1 - Month register at 5h keeps five BCD bits; bits 7..5 read zero.
// RULE2 - Year register at 6h keeps all eight bits and reads them back.
// RULE3 - Trim register at 7h: crystal select, trim value; cleared while oscillator stopped.
// RULE4 - Crystal select 0 means 32.768 kHz, 1 means 32.000 kHz nominal count.
// RULE5 - Seconds advance every 32768 pulses, or 32000 with the other crystal.
// RULE6 - Trim applies only to the second counted at seconds 00, 20 or 40.
// RULE7 - Sign zero lengthens that second by (low six bits minus one) times two.
// RULE8 - Sign one shortens that second by (inverted low bits plus one) times two.
// RULE9 - Trim bits 5..1 all zero leave the pulse count unchanged.
// RULE10 - Trim never alters the oscillator or the 32 kHz clock output.
// RULE11 - Two alarm sets at 8h..Ah and Bh..Dh; minute bit 7 reads zero.
// RULE12 - Alarm hour bit 5 is PM in 12-hour mode, tens-of-twenty otherwise.
// RULE13 - In 12-hour mode midnight is 12 and noon 32, PM as upper digit.
// RULE14 - Weekday mask bits 0..6 enable weekday values 0..6; bit 7 reads zero.
// RULE15 - An alarm with an all-zero weekday mask never matches.
// RULE16 - Host programs only valid BCD alarm times; impossible times never match.
// RULE17 - Match flag sets when enabled alarm equals weekday, hour and minute.
// RULE18 - Alarm flags act only while enabled; a disabled alarm reads zero.
// RULE19 - Alarms compare once per minute, when seconds roll over to zero.
// RULE20 - Compare all seven minute bits and six hour bits for equality.
`timescale 1ns/1ns
module rtc_calendar_trim_alarm (
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rstn,
   // Register port
   input  wire logic [3:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic [7:0] reg_wdata,
   output logic [7:0]      reg_rdata,
   // Oscillator pin and undivided clock output
   input  wire logic       osc_pin,
   output logic            clk32_out,
   // Live clock counters and control bits
   input  wire logic       osc_stopped_flag,
   input  wire logic [7:0] cur_seconds,
   input  wire logic [6:0] cur_minute,
   input  wire logic [5:0] cur_hour,
   input  wire logic [2:0] weekday_count,
   input  wire logic       alarm_a_enable,
   input  wire logic       alarm_b_enable,
   input  wire logic       alarm_a_flag_clear,
   input  wire logic       alarm_b_flag_clear,
   // Second event and alarm flags
   output logic            second_tick,
   output logic            alarm_a_match_flag,
   output logic            alarm_b_match_flag
);
   import rtc_pkg::*;

   logic [7:0]  month_count;
   logic [7:0]  year_count;
   logic [7:0]  clock_trim;
   logic [7:0]  alarm_a_minute;
   logic [7:0]  alarm_a_hour;
   logic [7:0]  alarm_a_weekdays;
   logic [7:0]  alarm_b_minute;
   logic [7:0]  alarm_b_hour;
   logic [7:0]  alarm_b_weekdays;
   logic        osc_sync1;
   logic        osc_sync2;
   logic        osc_prev;
   logic        seconds_were_zero;
   logic        flag_a;
   logic        flag_b;
   logic [7:0]  next_reg_rdata;
   logic        next_flag_a;
   logic        next_flag_b;
   wire         osc_edge;
   wire         crystal_select;
   wire         trim_sign;
   wire  [5:0]  trim_mag;
   wire         trim_window;
   wire         trim_active;
   wire  [15:0] nominal_pulses;
   wire  [15:0] slow_adjust;
   wire  [15:0] fast_adjust;
   wire  [15:0] period;
   wire         minute_rollover;
   wire         hit_a;
   wire         hit_b;

   // -------------------------------------------------------------------------
   // Alarm comparison
   // -------------------------------------------------------------------------
   // Weekday value 7 has no mask bit and therefore never matches.
   function automatic logic alarm_hit(input logic [7:0] a_min,
                                      input logic [7:0] a_hour,
                                      input logic [7:0] a_days,
                                      input logic [6:0] minute,
                                      input logic [5:0] hour,
                                      input logic [2:0] day);
      logic day_ok;
      day_ok = (day != RTC_WEEKDAY_ILLEGAL) && a_days[day];         // RULE14 RULE15
      return day_ok && (a_min[6:0] == minute) && (a_hour[5:0] == hour); // RULE12 RULE13 RULE20
   endfunction

   // -------------------------------------------------------------------------
   // Oscillator synchroniser and clock output
   // -------------------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         osc_sync1 <= 1'b0;
         osc_sync2 <= 1'b0;
         osc_prev  <= 1'b0;
         clk32_out <= 1'b0;
      end else begin
         osc_sync1 <= osc_pin;
         osc_sync2 <= osc_sync1;
         osc_prev  <= osc_sync2;
         clk32_out <= osc_sync2; // RULE10
      end
   end

   assign osc_edge = osc_sync2 && !osc_prev;

   // -------------------------------------------------------------------------
   // Per-second pulse count with trimming
   // -------------------------------------------------------------------------
   assign crystal_select = clock_trim[RTC_TRIM_XSEL_BIT];
   assign trim_sign      = clock_trim[RTC_TRIM_SIGN_BIT];
   assign trim_mag       = clock_trim[5:0];
   assign nominal_pulses = crystal_select ? RTC_PULSES_32000 : RTC_PULSES_32768; // RULE4 RULE5
   assign trim_window    = (cur_seconds == RTC_TRIM_SEC_00) ||
                           (cur_seconds == RTC_TRIM_SEC_20) ||
                           (cur_seconds == RTC_TRIM_SEC_40); // RULE6
   assign trim_active    = trim_window && (trim_mag[5:1] != 5'h00); // RULE9
   assign slow_adjust    = 16'({10'h000, trim_mag} - 16'h0001) << 1; // RULE7
   assign fast_adjust    = 16'({10'h000, ~trim_mag} + 16'h0001) << 1; // RULE8
   assign period         = !trim_active ? nominal_pulses :
                           trim_sign    ? 16'(nominal_pulses - fast_adjust) :
                                          16'(nominal_pulses + slow_adjust);

   rtc_sec_prescaler #(
      .CNT_W       (RTC_CNT_W)
   ) u_prescaler (
      .ref_clk     (ref_clk),
      .rstn        (rstn),
      .osc_edge    (osc_edge),
      .period      (period),
      .second_tick (second_tick)
   );

   // -------------------------------------------------------------------------
   // Register writes
   // -------------------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         month_count      <= RTC_REG_RESET;
         year_count       <= RTC_REG_RESET;
         alarm_a_minute   <= RTC_REG_RESET;
         alarm_a_hour     <= RTC_REG_RESET;
         alarm_a_weekdays <= RTC_REG_RESET;
         alarm_b_minute   <= RTC_REG_RESET;
         alarm_b_hour     <= RTC_REG_RESET;
         alarm_b_weekdays <= RTC_REG_RESET;
      end else if (reg_wr) begin
         unique case (reg_addr)
            RTC_ADDR_MONTH:      month_count      <= reg_wdata & RTC_MONTH_MASK;   // RULE1
            RTC_ADDR_YEAR:       year_count       <= reg_wdata & RTC_YEAR_MASK;    // RULE2
            RTC_ADDR_A_MINUTE:   alarm_a_minute   <= reg_wdata & RTC_MINUTE_MASK;  // RULE11
            RTC_ADDR_A_HOUR:     alarm_a_hour     <= reg_wdata & RTC_HOUR_MASK;
            RTC_ADDR_A_WEEKDAYS: alarm_a_weekdays <= reg_wdata & RTC_WEEKDAY_MASK; // RULE14
            RTC_ADDR_B_MINUTE:   alarm_b_minute   <= reg_wdata & RTC_MINUTE_MASK;  // RULE11
            RTC_ADDR_B_HOUR:     alarm_b_hour     <= reg_wdata & RTC_HOUR_MASK;
            RTC_ADDR_B_WEEKDAYS: alarm_b_weekdays <= reg_wdata & RTC_WEEKDAY_MASK; // RULE14
            default: begin
            end
         endcase
      end
   end

   // The stopped oscillator holds the trim register at its default.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         clock_trim <= RTC_TRIM_RESET;
      end else if (osc_stopped_flag) begin
         clock_trim <= RTC_TRIM_RESET; // RULE3
      end else if (reg_wr && reg_addr == RTC_ADDR_TRIM) begin
         clock_trim <= reg_wdata; // RULE3
      end
   end

   // -------------------------------------------------------------------------
   // Register read
   // -------------------------------------------------------------------------
   always_comb begin
      unique case (reg_addr)
         RTC_ADDR_MONTH:      next_reg_rdata = month_count & RTC_MONTH_MASK; // RULE1
         RTC_ADDR_YEAR:       next_reg_rdata = year_count;                   // RULE2
         RTC_ADDR_TRIM:       next_reg_rdata = clock_trim;                   // RULE3
         RTC_ADDR_A_MINUTE:   next_reg_rdata = alarm_a_minute;
         RTC_ADDR_A_HOUR:     next_reg_rdata = alarm_a_hour;
         RTC_ADDR_A_WEEKDAYS: next_reg_rdata = alarm_a_weekdays;
         RTC_ADDR_B_MINUTE:   next_reg_rdata = alarm_b_minute;
         RTC_ADDR_B_HOUR:     next_reg_rdata = alarm_b_hour;
         RTC_ADDR_B_WEEKDAYS: next_reg_rdata = alarm_b_weekdays;
         default:             next_reg_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= next_reg_rdata;
      end
   end

   // -------------------------------------------------------------------------
   // Alarm match flags
   // -------------------------------------------------------------------------
   assign minute_rollover = (cur_seconds == RTC_TRIM_SEC_00) && !seconds_were_zero; // RULE19
   assign hit_a = minute_rollover &&
                  alarm_hit(alarm_a_minute, alarm_a_hour, alarm_a_weekdays,
                            cur_minute, cur_hour, weekday_count); // RULE17
   assign hit_b = minute_rollover &&
                  alarm_hit(alarm_b_minute, alarm_b_hour, alarm_b_weekdays,
                            cur_minute, cur_hour, weekday_count); // RULE17
   // A match in the cycle of a clear wins, and a disabled alarm drops its flag.
   assign next_flag_a = alarm_a_enable && (hit_a || (flag_a && !alarm_a_flag_clear)); // RULE18
   assign next_flag_b = alarm_b_enable && (hit_b || (flag_b && !alarm_b_flag_clear)); // RULE18

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         seconds_were_zero <= 1'b1;
         flag_a            <= 1'b0;
         flag_b            <= 1'b0;
      end else begin
         seconds_were_zero <= (cur_seconds == RTC_TRIM_SEC_00);
         flag_a            <= next_flag_a;
         flag_b            <= next_flag_b;
      end
   end

   assign alarm_a_match_flag = flag_a && alarm_a_enable; // RULE18
   assign alarm_b_match_flag = flag_b && alarm_b_enable; // RULE18

   // -------------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------------
   property p_month_upper_zero;
      @(posedge ref_clk) disable iff (!rstn)
      (reg_addr == RTC_ADDR_MONTH) |=> (reg_rdata[7:5] == 3'h0);
   endproperty
   a_month_upper_zero: assert property (p_month_upper_zero) // RULE1
      else $error("month read shows nonzero upper bits");

   property p_year_readback;
      @(posedge ref_clk) disable iff (!rstn)
      (reg_wr && reg_addr == RTC_ADDR_YEAR) ##1 (!reg_wr && reg_addr == RTC_ADDR_YEAR)
      |=> (reg_rdata == $past(reg_wdata, 2));
   endproperty
   a_year_readback: assert property (p_year_readback) // RULE2
      else $error("year register does not read back as written");

   property p_trim_cleared;
      @(posedge ref_clk) disable iff (!rstn)
      osc_stopped_flag |=> (clock_trim == 8'h00);
   endproperty
   a_trim_cleared: assert property (p_trim_cleared) // RULE3
      else $error("trim register not cleared while oscillator stopped");

   property p_nominal_outside_window;
      @(posedge ref_clk) disable iff (!rstn)
      !trim_window |-> (period == (crystal_select ? 16'h7D00 : 16'h8000));
   endproperty
   a_nominal_outside_window: assert property (p_nominal_outside_window) // RULE4 RULE5 RULE6
      else $error("pulse count differs from nominal outside trim window");

   property p_slow_trim;
      @(posedge ref_clk) disable iff (!rstn)
      (trim_window && !trim_sign && trim_mag[5:1] != 5'h00)
      |-> (period == 16'(nominal_pulses + 16'(2 * (trim_mag - 1))));
   endproperty
   a_slow_trim: assert property (p_slow_trim) // RULE7
      else $error("lengthened second has the wrong pulse count");

   property p_fast_trim;
      @(posedge ref_clk) disable iff (!rstn)
      (trim_window && trim_sign && trim_mag[5:1] != 5'h00)
      |-> (period == 16'(nominal_pulses - 16'(2 * ({1'b0, ~trim_mag} + 7'h01))));
   endproperty
   a_fast_trim: assert property (p_fast_trim) // RULE8
      else $error("shortened second has the wrong pulse count");

   property p_trim_neutral;
      @(posedge ref_clk) disable iff (!rstn)
      (trim_mag[5:1] == 5'h00) |-> (period == nominal_pulses);
   endproperty
   a_trim_neutral: assert property (p_trim_neutral) // RULE9
      else $error("neutral trim setting changed the pulse count");

   property p_clock_out_follows;
      @(posedge ref_clk) disable iff (!rstn)
      ##1 (clk32_out == $past(osc_sync2));
   endproperty
   a_clock_out_follows: assert property (p_clock_out_follows) // RULE10
      else $error("clock output does not follow the oscillator");

   property p_alarm_reads_masked;
      @(posedge ref_clk) disable iff (!rstn)
      (reg_addr == RTC_ADDR_A_MINUTE || reg_addr == RTC_ADDR_B_MINUTE ||
       reg_addr == RTC_ADDR_A_WEEKDAYS || reg_addr == RTC_ADDR_B_WEEKDAYS)
      |=> (reg_rdata[7] == 1'b0);
   endproperty
   a_alarm_reads_masked: assert property (p_alarm_reads_masked) // RULE11 RULE14
      else $error("alarm minute or weekday read shows bit 7 set");

   property p_empty_mask_silent;
      @(posedge ref_clk) disable iff (!rstn)
      $rose(flag_a) |-> ($past(alarm_a_weekdays[6:0]) != 7'h00);
   endproperty
   a_empty_mask_silent: assert property (p_empty_mask_silent) // RULE15
      else $error("alarm with empty weekday mask raised its flag");

   property p_match_sets_flag;
      @(posedge ref_clk) disable iff (!rstn)
      (hit_b && alarm_b_enable) |=> alarm_b_match_flag [*1] ##0 flag_b;
   endproperty
   a_match_sets_flag: assert property (p_match_sets_flag) // RULE17
      else $error("enabled alarm match did not set its flag");

   property p_disabled_reads_zero;
      @(posedge ref_clk) disable iff (!rstn)
      !alarm_a_enable |-> !alarm_a_match_flag;
   endproperty
   a_disabled_reads_zero: assert property (p_disabled_reads_zero) // RULE18
      else $error("disabled alarm shows its match flag");

   property p_set_on_rollover;
      @(posedge ref_clk) disable iff (!rstn)
      ($rose(flag_a) || $rose(flag_b))
      |-> ($past(cur_seconds) == 8'h00 && !$past(seconds_were_zero));
   endproperty
   a_set_on_rollover: assert property (p_set_on_rollover) // RULE19
      else $error("alarm flag set outside the minute rollover");

endmodule

// [testbench/rtc_host_model.sv]
`timescale 1ns/1ns
module rtc_host_model (
   // Clock
   input  wire logic       ref_clk,
   // Register port
   output logic [3:0]      reg_addr,
   output logic            reg_wr,
   output logic [7:0]      reg_wdata,
   input  wire logic [7:0] reg_rdata
);
   // The idle port parks on an unmapped address with no write pending.
   initial begin
      reg_addr  = 4'hF;
      reg_wr    = 1'b0;
      reg_wdata = 8'h00;
   end

   // One write strobe, raised and dropped at falling edges, then one idle cycle so that
   // a following write never lowers and raises the strobe in the same instant.
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(negedge ref_clk);
      reg_wr    = 1'b0;
      reg_wdata = ~d;
      @(negedge ref_clk);
   endtask

   // The address is held over one rising edge and the data taken at the next falling edge.
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      reg_addr = a;
      @(negedge ref_clk);
      d = reg_rdata;
   endtask
endmodule

// [testbench/tb_rtc_calendar_trim_alarm.sv]
`timescale 1ns/1ns
module tb_rtc_calendar_trim_alarm;
   logic       ref_clk, rstn, osc_pin, osc_stopped_flag, reg_wr;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, cur_seconds, tick_count;
   logic [6:0] cur_minute;
   logic [5:0] cur_hour;
   logic [2:0] weekday_count;
   logic       alarm_a_enable, alarm_b_enable, alarm_a_flag_clear, alarm_b_flag_clear;
   logic       clk32_out, second_tick, alarm_a_match_flag, alarm_b_match_flag;
   int         bad_count = 0;
   int         tests_run = 0;

   rtc_calendar_trim_alarm dut (
      .ref_clk(ref_clk), .rstn(rstn),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .osc_pin(osc_pin), .clk32_out(clk32_out),
      .osc_stopped_flag(osc_stopped_flag), .cur_seconds(cur_seconds),
      .cur_minute(cur_minute), .cur_hour(cur_hour), .weekday_count(weekday_count),
      .alarm_a_enable(alarm_a_enable), .alarm_b_enable(alarm_b_enable),
      .alarm_a_flag_clear(alarm_a_flag_clear), .alarm_b_flag_clear(alarm_b_flag_clear),
      .second_tick(second_tick), .alarm_a_match_flag(alarm_a_match_flag),
      .alarm_b_match_flag(alarm_b_match_flag)
   );

   rtc_host_model host (
      .ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata)
   );

   always #5 ref_clk = ~ref_clk;

   always @(posedge ref_clk) begin
      if (second_tick === 1'b1) tick_count <= tick_count + 8'h01;
   end

   // -------------------------------------------------------------------------
   // Shared helpers
   // -------------------------------------------------------------------------
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic test_done();
      if (bad_count == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // Seconds roll from 59 to 00, the moment at which alarms are compared.
   task automatic roll();
      cur_seconds = 8'h59;
      @(negedge ref_clk);
      cur_seconds = 8'h00;
      repeat (2) @(negedge ref_clk);
   endtask

   // -------------------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------------------
   task automatic t_regs();
      logic [7:0] v;
      logic [7:0] mask [5:13] = '{8'h1F, 8'hFF, 8'hFF, 8'h7F, 8'h3F, 8'h7F, 8'h7F, 8'h3F, 8'h7F};
      for (int a = 5; a <= 13; a++) begin
         host.rd(a[3:0], v);
         check("value after reset", v, 8'h00);
         host.wr(a[3:0], 8'hFF);
         host.rd(a[3:0], v);
         check("masked readback", v, mask[a]);
      end
      host.wr(4'h2, 8'hFF);
      host.rd(4'h2, v);
      check("unmapped read", v, 8'h00);
      osc_stopped_flag = 1'b1;
      host.wr(4'h7, 8'h55);
      host.rd(4'h7, v);
      check("trim while stopped", v, 8'h00);
      osc_stopped_flag = 1'b0;
      host.rd(4'h7, v);
      check("trim after stop", v, 8'h00);
   endtask

   task automatic t_alarm();
      // Only valid BCD times are programmed: 12:30 PM on alarm A and 12:30 AM on alarm B, both on weekday 1.
      host.wr(4'h8, 8'h30);
      host.wr(4'h9, 8'h32);
      host.wr(4'hA, 8'h02);
      host.wr(4'hB, 8'h30);
      host.wr(4'hC, 8'h12);
      host.wr(4'hD, 8'h02);
      cur_minute = 7'h30;
      cur_hour = 6'h32;
      weekday_count = 3'h1;
      alarm_a_enable = 1'b1;
      alarm_b_enable = 1'b1;
      roll();
      check("alarm a noon", {7'h00, alarm_a_match_flag}, 8'h01);
      check("alarm b midnight", {7'h00, alarm_b_match_flag}, 8'h00);
      alarm_a_flag_clear = 1'b1;
      @(negedge ref_clk);
      alarm_a_flag_clear = 1'b0;
      repeat (4) @(negedge ref_clk);
      check("alarm a seconds held", {7'h00, alarm_a_match_flag}, 8'h00);
      host.wr(4'hC, 8'h32);
      host.wr(4'hD, 8'h00);
      roll();
      check("alarm b empty mask", {7'h00, alarm_b_match_flag}, 8'h00);
      host.wr(4'hD, 8'h02);
      alarm_a_enable = 1'b0;
      roll();
      check("alarm b match", {7'h00, alarm_b_match_flag}, 8'h01);
      alarm_a_enable = 1'b1;
      alarm_b_enable = 1'b0;
      @(negedge ref_clk);
      check("alarm b disabled", {7'h00, alarm_b_match_flag}, 8'h00);
      alarm_b_enable = 1'b1;
      @(negedge ref_clk);
      check("alarm a was disabled", {7'h00, alarm_a_match_flag}, 8'h00);
      check("alarm b flag dropped", {7'h00, alarm_b_match_flag}, 8'h00);
      weekday_count = 3'h2;
      roll();
      check("alarm a other day", {7'h00, alarm_a_match_flag}, 8'h00);
   endtask

   // A slow trim is written outside and read inside its window; then a fast trim on the
   // 32.000 kHz crystal is counted through one whole second at second 00.
   task automatic t_trim();
      int         n;
      logic [7:0] v;
      cur_seconds = 8'h21;
      host.wr(4'h7, 8'h07);
      cur_seconds = 8'h20;
      host.rd(4'h7, v);
      check("slow trim readback", v, 8'h07);
      n = 32000 - (6'(~6'h3E) + 1) * 2;
      host.wr(4'h7, 8'hFE);
      cur_seconds = 8'h00;
      tick_count = 8'h00;
      repeat (n - 1) begin
         osc_pin = 1'b1;
         @(negedge ref_clk);
         osc_pin = 1'b0;
         @(negedge ref_clk);
      end
      repeat (10) @(negedge ref_clk);
      check("ticks before last pulse", tick_count, 8'h00);
      check("clock output low", {7'h00, clk32_out}, 8'h00);
      osc_pin = 1'b1;
      repeat (8) @(negedge ref_clk);
      check("ticks after last pulse", tick_count, 8'h01);
      check("clock output high", {7'h00, clk32_out}, 8'h01);
   endtask

   // -------------------------------------------------------------------------
   // Main sequence and watchdog
   // -------------------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      rstn = 1'b0;
      osc_pin = 1'b0;
      osc_stopped_flag = 1'b0;
      cur_seconds = 8'h00;
      cur_minute = 7'h00;
      cur_hour = 6'h00;
      weekday_count = 3'h0;
      alarm_a_enable = 1'b0;
      alarm_b_enable = 1'b0;
      alarm_a_flag_clear = 1'b0;
      alarm_b_flag_clear = 1'b0;
      tick_count = 8'h00;
      repeat (3) @(negedge ref_clk);
      rstn = 1'b1;
      t_regs();
      t_alarm();
      t_trim();
      test_done();
   end

   initial begin
      repeat (100000) @(posedge ref_clk);
      bad_count++;
      test_done();
   end
endmodule
